// >>> hw/rdac_pkg.sv
// Package for the dual alarm compare block: register map, fields and resets
package rdac_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] RDAC_IDX_A1_DOM   = 8'h14;
  localparam logic [7:0] RDAC_IDX_A2_SEC   = 8'h15;
  localparam logic [7:0] RDAC_IDX_A2_MIN   = 8'h16;
  localparam logic [7:0] RDAC_IDX_A2_HOUR  = 8'h17;
  localparam logic [7:0] RDAC_IDX_A2_WDAY  = 8'h18;
  localparam logic [7:0] RDAC_IDX_A2_MONTH = 8'h19;
  localparam logic [7:0] RDAC_IDX_A2_YEAR  = 8'h1a;
  localparam logic [7:0] RDAC_IDX_A2_DOM   = 8'h1b;
  localparam logic [7:0] RDAC_IDX_TIME_OK  = 8'h25;
  localparam logic [7:0] RDAC_IDX_IRQ_STS  = 8'h30;
  localparam logic [7:0] RDAC_IDX_IRQ_MSK  = 8'h31;
  localparam logic [7:0] RDAC_IDX_MODE     = 8'h32;

  // Field positions
  localparam int RDAC_ENABLE_BIT = 7;
  localparam int RDAC_PM_BIT     = 6;
  localparam int RDAC_IRQ_A1_BIT = 0;
  localparam int RDAC_IRQ_A2_BIT = 1;
  localparam int RDAC_IRQ_W      = 2;
  localparam int RDAC_FLAG_BIT   = 0;

  // Field widths and address decode
  localparam int RDAC_ADR_LSB = 2;
  localparam int RDAC_IDX_W   = 8;
  localparam int RDAC_SEC_W   = 7;
  localparam int RDAC_MIN_W   = 7;
  localparam int RDAC_HOUR_W  = 6;
  localparam int RDAC_WDAY_W  = 7;
  localparam int RDAC_MONTH_W = 5;
  localparam int RDAC_YEAR_W  = 7;
  localparam int RDAC_DOM_W   = 6;

  // Implemented-bit masks
  localparam logic [7:0] RDAC_MSK_DOM   = 8'h8f | 8'h30;
  localparam logic [7:0] RDAC_MSK_7BIT  = 8'hff;
  localparam logic [7:0] RDAC_MSK_HOUR  = 8'hff;
  localparam logic [7:0] RDAC_MSK_MONTH = 8'h9f;
  localparam logic [7:0] RDAC_MSK_FLAG  = 8'h01;
  localparam logic [7:0] RDAC_MSK_IRQ   = 8'h03;

  // Reset values
  localparam logic [7:0] RDAC_RST_ZERO  = 8'h00;
  localparam logic [7:0] RDAC_RST_MIN   = 8'h01;
  localparam logic [7:0] RDAC_RST_WDAY  = 8'h01;
  localparam logic [7:0] RDAC_RST_MODE  = 8'h01;

endpackage

// >>> hw/rdac_alarm_top.sv
// Alarm compare registers and match logic with a Wishbone register port
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps

// Functional notes
// - Alarm 1 fires on enabled day-of-month match
// - Bit 7 enables each alarm field's compare
// - Alarm 2 enabled minutes match fires
// - Alarm 2 enabled hours match fires
// - PM bit compared only in 12-hour mode
// - Weekday field one-hot, match fires alarm 2
// - Alarm 2 enabled day-of-month match fires
module rdac_alarm_top
  import rdac_pkg::*;
#(
  parameter int ADR_W = 10
) (
  // Clock, reset, enable
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  // Wishbone slave
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  input  wire logic             we_i,
  input  wire logic [ADR_W-1:0] adr_i,
  input  wire logic [3:0]       sel_i,
  input  wire logic [31:0]      dat_i,
  output logic      [31:0]      dat_o,
  output logic                  ack_o,
  // Live calendar counters, same clock
  input  wire logic [6:0]       cnt_sec_i,
  input  wire logic [6:0]       cnt_min_i,
  input  wire logic [5:0]       cnt_hour_i,
  input  wire logic             cnt_pm_i,
  input  wire logic [6:0]       cnt_wday_i,
  input  wire logic [4:0]       cnt_month_i,
  input  wire logic [7:0]       cnt_year_i,
  input  wire logic [5:0]       cnt_dom_i,
  // Alarm events and interrupt
  output logic                  first_alarm_irq_o,
  output logic                  second_alarm_irq_o,
  output logic                  irq_o
);

  // Register state
  logic [7:0]  a1_dom_r;
  logic [7:0]  a2_sec_r;
  logic [7:0]  a2_min_r;
  logic [7:0]  a2_hour_r;
  logic [7:0]  a2_wday_r;
  logic [7:0]  a2_month_r;
  logic [7:0]  a2_year_r;
  logic [7:0]  a2_dom_r;
  logic        time_ok_r;
  logic        hour24_r;
  logic [RDAC_IRQ_W-1:0] sts_r;
  logic [RDAC_IRQ_W-1:0] msk_r;
  logic [RDAC_IRQ_W-1:0] match_prev_r;
  logic        ack_r;
  logic [31:0] dat_r;
  logic        irq_r;

  // Bus decode and compare nets
  logic [7:0]  idx;
  logic        req;
  logic        wr;
  logic [7:0]  wdat;
  logic [7:0]  rd_nxt;
  logic        a1_match;
  logic        a2_match;
  logic        a2_any_en;
  logic        a2_all_ok;
  logic        hour_eq;
  logic [RDAC_IRQ_W-1:0] match_now;
  logic [RDAC_IRQ_W-1:0] rise;

  // Per-field compare results
  logic        sec_ok;
  logic        min_ok;
  logic        hour_ok;
  logic        wday_ok;
  logic        month_ok;
  logic        year_ok;
  logic        dom_ok;

  assign idx  = adr_i[RDAC_ADR_LSB +: RDAC_IDX_W];
  assign req  = cyc_i & stb_i;
  // Write lands on the edge where the master samples ack
  assign wr   = req & we_i & ack_r & sel_i[0];
  assign wdat = dat_i[7:0];

  // Bus handshake: ack one cycle after request, dropped the next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_r <= req & ~ack_r;
      if (req & ~ack_r) begin
        dat_r <= {24'h00_0000, rd_nxt};
      end
    end
  end

  // Read mux; unimplemented bits and unmapped addresses read zero
  always_comb begin
    case (idx)
      RDAC_IDX_A1_DOM:   rd_nxt = a1_dom_r;
      RDAC_IDX_A2_SEC:   rd_nxt = a2_sec_r;
      RDAC_IDX_A2_MIN:   rd_nxt = a2_min_r;
      RDAC_IDX_A2_HOUR:  rd_nxt = a2_hour_r;
      RDAC_IDX_A2_WDAY:  rd_nxt = a2_wday_r;
      RDAC_IDX_A2_MONTH: rd_nxt = a2_month_r;
      RDAC_IDX_A2_YEAR:  rd_nxt = a2_year_r;
      RDAC_IDX_A2_DOM:   rd_nxt = a2_dom_r;
      RDAC_IDX_TIME_OK:  rd_nxt = {7'h00, time_ok_r};
      RDAC_IDX_IRQ_STS:  rd_nxt = {6'h00, sts_r};
      RDAC_IDX_IRQ_MSK:  rd_nxt = {6'h00, msk_r};
      RDAC_IDX_MODE:     rd_nxt = {7'h00, hour24_r};
      default:           rd_nxt = RDAC_RST_ZERO;
    endcase
  end

  // Alarm 1 day of month; reserved bit 6 is not stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a1_dom_r <= RDAC_RST_ZERO;
    end else if (ce_i && wr && idx == RDAC_IDX_A1_DOM) begin
      a1_dom_r <= wdat & RDAC_MSK_DOM;
    end
  end

  // Alarm 2 seconds
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a2_sec_r <= RDAC_RST_ZERO;
    end else if (ce_i && wr && idx == RDAC_IDX_A2_SEC) begin
      a2_sec_r <= wdat & RDAC_MSK_7BIT;
    end
  end

  // Alarm 2 minutes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a2_min_r <= RDAC_RST_MIN;
    end else if (ce_i && wr && idx == RDAC_IDX_A2_MIN) begin
      a2_min_r <= wdat & RDAC_MSK_7BIT;
    end
  end

  // Alarm 2 hours with PM bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a2_hour_r <= RDAC_RST_ZERO;
    end else if (ce_i && wr && idx == RDAC_IDX_A2_HOUR) begin
      a2_hour_r <= wdat & RDAC_MSK_HOUR;
    end
  end

  // Alarm 2 one-hot weekday
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a2_wday_r <= RDAC_RST_WDAY;
    end else if (ce_i && wr && idx == RDAC_IDX_A2_WDAY) begin
      a2_wday_r <= wdat & RDAC_MSK_7BIT;
    end
  end

  // Alarm 2 month; reserved bits 6:5 are not stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a2_month_r <= RDAC_RST_ZERO;
    end else if (ce_i && wr && idx == RDAC_IDX_A2_MONTH) begin
      a2_month_r <= wdat & RDAC_MSK_MONTH;
    end
  end

  // Alarm 2 year
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a2_year_r <= RDAC_RST_ZERO;
    end else if (ce_i && wr && idx == RDAC_IDX_A2_YEAR) begin
      a2_year_r <= wdat & RDAC_MSK_7BIT;
    end
  end

  // Alarm 2 day of month; reserved bit 6 is not stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a2_dom_r <= RDAC_RST_ZERO;
    end else if (ce_i && wr && idx == RDAC_IDX_A2_DOM) begin
      a2_dom_r <= wdat & RDAC_MSK_DOM;
    end
  end

  // Time-valid flag, set by software after loading the time
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      time_ok_r <= 1'b0;
    end else if (ce_i && wr && idx == RDAC_IDX_TIME_OK) begin
      time_ok_r <= wdat[RDAC_FLAG_BIT];
    end
  end

  // Hour mode, 1 selects 24-hour counting
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hour24_r <= RDAC_RST_MODE[RDAC_FLAG_BIT];
    end else if (ce_i && wr && idx == RDAC_IDX_MODE) begin
      hour24_r <= wdat[RDAC_FLAG_BIT];
    end
  end

  // Interrupt mask, 1 lets a status bit through
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      msk_r <= '0;
    end else if (ce_i && wr && idx == RDAC_IDX_IRQ_MSK) begin
      msk_r <= wdat[RDAC_IRQ_W-1:0];
    end
  end

  // Hour equality; the PM bit only counts in 12-hour mode
  always_comb begin
    hour_eq = (a2_hour_r[RDAC_HOUR_W-1:0] == cnt_hour_i);
    if (!hour24_r) begin
      hour_eq = hour_eq & (a2_hour_r[RDAC_PM_BIT] == cnt_pm_i);
    end
  end

  // A field whose enable is clear never blocks the match
  assign sec_ok    = ~a2_sec_r[RDAC_ENABLE_BIT]
                   | (a2_sec_r[RDAC_SEC_W-1:0] == cnt_sec_i);
  assign min_ok    = ~a2_min_r[RDAC_ENABLE_BIT]
                   | (a2_min_r[RDAC_MIN_W-1:0] == cnt_min_i);
  assign hour_ok   = ~a2_hour_r[RDAC_ENABLE_BIT] | hour_eq;
  assign wday_ok   = ~a2_wday_r[RDAC_ENABLE_BIT]
                   | (a2_wday_r[RDAC_WDAY_W-1:0] == cnt_wday_i);
  assign month_ok  = ~a2_month_r[RDAC_ENABLE_BIT]
                   | (a2_month_r[RDAC_MONTH_W-1:0] == cnt_month_i);
  assign year_ok   = ~a2_year_r[RDAC_ENABLE_BIT]
                   | ({1'b0, a2_year_r[RDAC_YEAR_W-1:0]} == cnt_year_i);
  assign dom_ok    = ~a2_dom_r[RDAC_ENABLE_BIT]
                   | (a2_dom_r[RDAC_DOM_W-1:0] == cnt_dom_i);

  assign a1_match  = a1_dom_r[RDAC_ENABLE_BIT]
                   & (a1_dom_r[RDAC_DOM_W-1:0] == cnt_dom_i);
  assign a2_any_en = a2_sec_r[RDAC_ENABLE_BIT] | a2_min_r[RDAC_ENABLE_BIT]
                   | a2_hour_r[RDAC_ENABLE_BIT] | a2_wday_r[RDAC_ENABLE_BIT]
                   | a2_month_r[RDAC_ENABLE_BIT] | a2_year_r[RDAC_ENABLE_BIT]
                   | a2_dom_r[RDAC_ENABLE_BIT];
  assign a2_all_ok = sec_ok & min_ok & hour_ok & wday_ok & month_ok & year_ok & dom_ok;
  assign a2_match  = a2_any_en & a2_all_ok;

  assign match_now = {a2_match, a1_match};
  // Edge detect: a match held high sets status only once
  assign rise      = match_now & ~match_prev_r;

  // Match history for edge detect
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      match_prev_r <= '0;
    end else if (ce_i) begin
      match_prev_r <= match_now;
    end
  end

  // Sticky status: a new match wins over a write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sts_r <= '0;
    end else if (ce_i) begin
      if (wr && idx == RDAC_IDX_IRQ_STS) begin
        sts_r <= (sts_r & ~wdat[RDAC_IRQ_W-1:0]) | rise;
      end else begin
        sts_r <= sts_r | rise;
      end
    end
  end

  // Level interrupt, one cycle behind status and mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_r <= 1'b0;
    end else if (ce_i) begin
      irq_r <= |(sts_r & msk_r);
    end
  end

  assign dat_o              = dat_r;
  assign ack_o              = ack_r;
  assign first_alarm_irq_o  = sts_r[RDAC_IRQ_A1_BIT];
  assign second_alarm_irq_o = sts_r[RDAC_IRQ_A2_BIT];
  assign irq_o              = irq_r;

endmodule

// >>> verification/rdac_alarm_monitor.sv
// Checker for the dual alarm compare block
`timescale 1ns/1ps
module rdac_alarm_monitor
  import rdac_pkg::*;
#(parameter int ADR_W = 10) (
  // Clock, reset, bus
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             ce_i,
  input wire logic             cyc_i,
  input wire logic             stb_i,
  input wire logic             we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [31:0]      dat_o,
  input wire logic             ack_o,
  // Counters and alarms
  input wire logic [6:0]       cnt_sec_i,
  input wire logic [6:0]       cnt_min_i,
  input wire logic [5:0]       cnt_hour_i,
  input wire logic             cnt_pm_i,
  input wire logic [6:0]       cnt_wday_i,
  input wire logic [4:0]       cnt_month_i,
  input wire logic [7:0]       cnt_year_i,
  input wire logic [5:0]       cnt_dom_i,
  input wire logic             first_alarm_irq_o,
  input wire logic             second_alarm_irq_o,
  input wire logic             irq_o
);
  logic [46:0] cv;
  logic        clr;
  assign cv = {cnt_sec_i, cnt_min_i, cnt_hour_i, cnt_pm_i, cnt_wday_i, cnt_month_i,
               cnt_year_i, cnt_dom_i};
  assign clr = ack_o && we_i && adr_i[9:2] == RDAC_IDX_IRQ_STS;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_ans;
    ack_o ##1 !ack_o;
  endsequence
  AST_BUS_ANSWER: assert property (cyc_i && stb_i && !ack_o |=> s_ans)
    else $error("request not answered in one cycle");
  AST_ACK_IDLE: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("ack without request");
  AST_DAT_UPPER:
    assert property (dat_o[31:8] == 24'h00_0000) else $error("upper read data set");
  AST_A1_HOLD:
    assert property ($fell(first_alarm_irq_o) |-> $past(clr)) else $error("alarm one lost");
  AST_A2_HOLD:
    assert property ($fell(second_alarm_irq_o) |-> $past(clr)) else $error("alarm two lost");
  AST_A1_CAUSE:
    assert property ($rose(first_alarm_irq_o) |-> $past(cnt_dom_i) != $past(cnt_dom_i, 2)
      || $past(ack_o, 2) || $past(rst_i, 2) || !$past(ce_i, 2))
      else $error("alarm one without cause");
  AST_A2_CAUSE:
    assert property ($rose(second_alarm_irq_o) |-> $past(cv) != $past(cv, 2)
      || $past(ack_o, 2) || $past(rst_i, 2) || !$past(ce_i, 2))
      else $error("alarm two without cause");
  AST_IRQ_QUIET: assert property (!first_alarm_irq_o && !second_alarm_irq_o |=> !irq_o)
    else $error("interrupt without status");
endmodule
bind rdac_alarm_top rdac_alarm_monitor #(.ADR_W(ADR_W)) u_mon (.*);

// >>> verification/tb_top.sv
// Testbench for the dual alarm compare block
`timescale 1ns/1ps
module tb_top;
  import rdac_pkg::*;
  logic        clk_i, ack_o, a1, a2, irq;
  logic        rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, pm = 1, ce = 1;
  logic [9:0]  adr_i = 0;
  logic [31:0] dat_i = 0, dat_o;
  logic [6:0]  sec = 7'h30, min = 7'h45, wday = 7'h08;
  logic [5:0]  hour = 6'h0b, dom = 6'h1c;
  logic [4:0]  month = 5'h0a;
  logic [7:0]  year = 8'h25, q;
  logic [7:0]  val [7] = '{8'h30, 8'h45, 8'h0b, 8'h08, 8'h0a, 8'h25, 8'h1c};
  logic [7:0]  rv [9] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
  int          n_fail = 0, num_checks = 0;
  rdac_alarm_top uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'h1), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .cnt_sec_i(sec), .cnt_min_i(min), .cnt_hour_i(hour),
    .cnt_pm_i(pm), .cnt_wday_i(wday), .cnt_month_i(month), .cnt_year_i(year),
    .cnt_dom_i(dom), .first_alarm_irq_o(a1), .second_alarm_irq_o(a2), .irq_o(irq));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h00_0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o[7:0];
    if (n >= 50) n_fail++;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    chk($sformatf("reg %h", idx), e, q);
  endtask
  task automatic alm(input logic e1, input logic e2, input logic ei);
    repeat (3) @(posedge clk_i);
    chk("alarm1", {7'h0, e1}, {7'h0, a1});
    chk("alarm2", {7'h0, e2}, {7'h0, a2});
    chk("irq", {7'h0, ei}, {7'h0, irq});
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clk_i = 0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    #500_000;
    n_fail++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 9; i++) rd(i < 8 ? 8'h14 + 8'(i) : RDAC_IDX_TIME_OK, rv[i]);
    rd(RDAC_IDX_MODE, 8'h01);
    bus(1, RDAC_IDX_A1_DOM, 8'hbf);
    rd(RDAC_IDX_A1_DOM, 8'hbf);
    bus(1, RDAC_IDX_A2_MONTH, 8'h8c);
    rd(RDAC_IDX_A2_MONTH, 8'h8c);
    bus(1, RDAC_IDX_A2_MONTH, 8'h00);
    bus(1, RDAC_IDX_TIME_OK, 8'h01);
    rd(RDAC_IDX_TIME_OK, 8'h01);
    bus(1, 8'h20, 8'hff);
    rd(8'h20, 8'h00);
    $display("test registers done");
    bus(1, RDAC_IDX_A1_DOM, 8'h1c);
    alm(0, 0, 0);
    bus(1, RDAC_IDX_A1_DOM, 8'h9c);
    alm(1, 0, 0);
    bus(1, RDAC_IDX_IRQ_MSK, 8'h03);
    alm(1, 0, 1);
    rd(RDAC_IDX_IRQ_STS, 8'h01);
    bus(1, RDAC_IDX_IRQ_STS, 8'h01);
    alm(0, 0, 0);
    bus(1, RDAC_IDX_A1_DOM, 8'h00);
    $display("test alarm one done");
    for (int i = 0; i < 7; i++) begin
      bus(1, 8'h15 + 8'(i), val[i] | 8'h80);
      alm(0, 1, 1);
      bus(1, RDAC_IDX_IRQ_STS, 8'h02);
      bus(1, 8'h15 + 8'(i), val[i]);
      alm(0, 0, 0);
    end
    $display("test alarm two fields done");
    bus(1, RDAC_IDX_MODE, 8'h00);
    bus(1, RDAC_IDX_A2_HOUR, 8'h8b);
    alm(0, 0, 0);
    bus(1, RDAC_IDX_A2_HOUR, 8'hcb);
    alm(0, 1, 1);
    bus(1, RDAC_IDX_IRQ_STS, 8'h02);
    bus(1, RDAC_IDX_A2_HOUR, 8'h00);
    bus(1, RDAC_IDX_A2_DOM, 8'h9d);
    bus(1, RDAC_IDX_A2_MIN, 8'hc5);
    alm(0, 0, 0);
    dom <= 6'h1d;
    alm(0, 1, 1);
    $display("test combined match done");
    bus(1, RDAC_IDX_IRQ_STS, 8'h02);
    dom <= 6'h1c;
    alm(0, 0, 0);
    ce  <= 1'b0;
    dom <= 6'h1d;
    alm(0, 0, 0);
    ce  <= 1'b1;
    alm(0, 1, 1);
    $display("test clock enable done");
    conclude();
  end
endmodule
